/* File: iefc_defs.svh */
/*
  Named offsets, bit positions, reset values and widths of the interrupt
  enable and flag control block.
  Assumes it is included by bare name before any use of its macros.
*/
`ifndef IEFC_DEFS_SVH
`define IEFC_DEFS_SVH

// register bus geometry
`define IEFC_ADDR_W       3
`define IEFC_DATA_W       8
`define IEFC_OFS_CONTROL  3'h0
`define IEFC_OFS_PE_ONE   3'h1
`define IEFC_OFS_PE_TWO   3'h2
`define IEFC_OFS_EV_STAT  3'h3
`define IEFC_OFS_EV_MASK  3'h4

// control register field positions
`define IEFC_B_GEN   7
`define IEFC_B_PGEN  6
`define IEFC_B_T0IE  5
`define IEFC_B_EXIE  4
`define IEFC_B_PCIE  3
`define IEFC_B_T0IF  2
`define IEFC_B_EXIF  1
`define IEFC_B_PCIF  0

// reset values and fixed numbers
`define IEFC_RST_BYTE  8'h00
`define IEFC_PC_W      14
`define IEFC_VECTOR    14'h0004
`define IEFC_EV_W      3
`define IEFC_RST_EV    3'h0
`define IEFC_EV_VECT   0
`define IEFC_EV_RET    1
`define IEFC_EV_PCHG   2

`endif

/* File: iefc_pkg.sv */
/*
  Types shared by the interrupt enable and flag control modules.
  Assumes iefc_defs.svh supplies the numeric constants.
*/
package iefc_pkg;
  // gray coded along idle -> vector -> in_isr
  typedef enum logic [1:0] {
    IEFC_IDLE   = 2'b00,
    IEFC_VECTOR = 2'b01,
    IEFC_IN_ISR = 2'b11
  } iefc_state_t;

  typedef logic [7:0] iefc_byte_t;
endpackage : iefc_pkg

/* File: iefc_pin_if.sv */
/*
  Carrier between the top module and the external pin edge detector.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface iefc_pin_if;
  logic pin_raw;     // asynchronous pin level
  logic edge_sel;    // 1 rising, 0 falling
  logic edge_pulse;  // one cycle per valid edge

  modport detector (input pin_raw, input edge_sel, output edge_pulse);
  modport owner (output pin_raw, output edge_sel, input edge_pulse);
endinterface : iefc_pin_if

/* File: iefc_edge_detect.sv */
/*
  External pin synchroniser and edge detector.
  Assumes the pin is asynchronous to clk and edge_sel is already
  synchronous.
*/
`timescale 1ns/1ps
module iefc_edge_detect
  import iefc_pkg::*;
(
  input wire logic      clk,   // system clock
  input wire logic      rst,   // synchronous reset, high
  input wire logic      ce,    // clock enable
  iefc_pin_if.detector  pin    // pin level in, edge pulse out
);
  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;
  logic primed_reg;

  // two flops before any logic reads the pin
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else if (ce) begin
      sync1_reg <= pin.pin_raw;
      sync2_reg <= sync1_reg;
    end
  end

  // history; primed masks the pulse only until the first cycle with ce high after reset
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_reg   <= 1'b0;
      primed_reg <= 1'b0;
    end else if (ce) begin
      prev_reg   <= sync2_reg;
      primed_reg <= 1'b1;
    end
  end

  // edge polarity chosen by the select level
  assign pin.edge_pulse = ce & primed_reg &
    (pin.edge_sel ? (sync2_reg & ~prev_reg) : (~sync2_reg & prev_reg));  // [R14]
endmodule : iefc_edge_detect

/* File: iefc_top.sv */
/*
  Interrupt enable and flag control: control register, two peripheral
  enable registers, core request, vectoring handshake and event status.
  Assumes the core, timer0 and peripheral flag sources share CLOCK, the
  per-pin change flags live in a register outside, and the external pin
  is asynchronous.
*/
// The address map and the plain strobed port are this design's own decisions.
// How it works
// R1: global enable passes or blocks every request
// R2: peripheral gate needed for enable-register sources
// R3: timer0 overflow sets flag, enable gates request
// R4: external event sets flag, enable gates request
// R5: summary flag is OR of per-pin flags
// R6: summary flag ignores writes, follows per-pin flags
// R7: flags set regardless of any enable
// R8: software clears flags before enabling sources
// R9: first enable register bit map
// R10: second enable register bit map
// R11: all control and enable bits reset zero
// R12: taking interrupt clears global enable, loads vector
// R13: return sets global enable again
// R14: edge select picks rising or falling edge
// R15: request is global and (core or gated peripheral)
`include "iefc_defs.svh"
`timescale 1ns/1ps
module iefc_top
  import iefc_pkg::*;
(
  input  wire logic                     CLOCK,                // system clock, 40 MHz
  input  wire logic                     RST,                  // synchronous reset, high
  input  wire logic                     CE,                   // clock enable, freezes state
  input  wire logic [`IEFC_ADDR_W-1:0]  ADDR,                 // register address
  input  wire logic [`IEFC_DATA_W-1:0]  WDATA,                // write data
  input  wire logic                     WR,                   // write strobe
  input  wire logic                     RD,                   // read strobe
  output logic      [`IEFC_DATA_W-1:0]  RDATA,                // read data, cycle after RD
  input  wire logic                     TIMER0_OVERFLOW,      // timer0 overflow pulse
  input  wire logic                     EXT_PIN,              // external interrupt pin
  input  wire logic                     EXT_EDGE_SELECT,      // 1 rising, 0 falling
  input  wire logic [7:0]               PER_PIN_CHANGE_FLAGS, // per-pin change flags
  input  wire logic [7:0]               PERIPH_FLAGS_ONE,     // first peripheral flags
  input  wire logic [7:0]               PERIPH_FLAGS_TWO,     // second peripheral flags
  input  wire logic                     RETURN_FROM_IRQ,      // core executes return
  output logic                          IRQ_REQ,              // request level to core
  output logic                          VECTOR_LOAD,          // flush, push pc, jump
  output logic      [`IEFC_PC_W-1:0]    VECTOR_ADDR,          // vector address
  output logic                          IRQ                   // event interrupt level
);

  // does any flag meet its enable
  function automatic logic any_enabled(input iefc_byte_t flags,
                                       input iefc_byte_t en);
    any_enabled = |(flags & en);
  endfunction : any_enabled

  // gate one selected bit of a flag byte by the same bit of an enable byte
  function automatic logic bit_enabled(input iefc_byte_t flags,
                                       input iefc_byte_t en,
                                       input int         pos);
    bit_enabled = flags[pos] & en[pos];
  endfunction : bit_enabled

  // control register bits
  logic global_irq_enable_reg;
  logic peripheral_gating_enable_reg;
  logic timer0_overflow_enable_reg;
  logic ext_pin_enable_reg;
  logic pin_change_enable_reg;
  logic timer0_overflow_flag_reg;
  logic ext_pin_flag_reg;
  logic pin_change_summary_flag_reg;

  // peripheral enable registers
  iefc_byte_t peripheral_enable_one_reg;
  iefc_byte_t peripheral_enable_two_reg;

  // event status and mask
  logic [`IEFC_EV_W-1:0] ev_status_reg;
  logic [`IEFC_EV_W-1:0] ev_mask_reg;
  logic [`IEFC_EV_W-1:0] ev_set;

  // sequencer
  iefc_state_t state_reg;
  iefc_state_t state_next;

  // bus and datapath
  iefc_byte_t  control_view;
  iefc_byte_t  rdata_reg;
  iefc_byte_t  rdata_next;
  logic        wr_control;
  logic        wr_pe_one;
  logic        wr_pe_two;
  logic        wr_ev_stat;
  logic        wr_ev_mask;
  logic        ext_edge;
  logic        core_pending;
  logic        periph_pending;
  logic        irq_req;
  logic        take;
  logic        summary_now;
  logic        vector_load_reg;
  logic [`IEFC_PC_W-1:0] vector_addr_reg;

  iefc_pin_if pin_bus ();

  // pin side of the carrier
  assign pin_bus.pin_raw  = EXT_PIN;
  assign pin_bus.edge_sel = EXT_EDGE_SELECT;
  assign ext_edge         = pin_bus.edge_pulse;

  // external pin synchroniser and edge detector
  iefc_edge_detect u_edge (
    .clk (CLOCK),
    .rst (RST),
    .ce  (CE),
    .pin (pin_bus.detector)
  );

  // address decode; writes while CE is low are dropped with the rest
  assign wr_control = WR && (ADDR == `IEFC_OFS_CONTROL);
  assign wr_pe_one  = WR && (ADDR == `IEFC_OFS_PE_ONE);
  assign wr_pe_two  = WR && (ADDR == `IEFC_OFS_PE_TWO);
  assign wr_ev_stat = WR && (ADDR == `IEFC_OFS_EV_STAT);
  assign wr_ev_mask = WR && (ADDR == `IEFC_OFS_EV_MASK);

  // summary of the per-pin flags, recomputed every cycle
  assign summary_now = |PER_PIN_CHANGE_FLAGS;  // [R5]

  // core sources, each flag through its own enable
  assign core_pending =
    (timer0_overflow_flag_reg & timer0_overflow_enable_reg) |      // [R3]
    (ext_pin_flag_reg & ext_pin_enable_reg) |                      // [R4]
    (pin_change_summary_flag_reg & pin_change_enable_reg);         // [R5]

  // peripheral sources; bit i of each enable register gates flag i
  assign periph_pending =
    any_enabled(PERIPH_FLAGS_ONE, peripheral_enable_one_reg) |     // [R9]
    any_enabled(PERIPH_FLAGS_TWO, peripheral_enable_two_reg);      // [R10]

  // one request level: global gate over core and gated peripheral terms
  assign irq_req = global_irq_enable_reg &                         // [R1] [R15]
                   (core_pending |
                    (peripheral_gating_enable_reg & periph_pending)); // [R2]

  // a request is taken at once; the core must act on VECTOR_LOAD
  assign take    = irq_req && CE;
  assign IRQ_REQ = irq_req;

  // global enable: taking clears it, return sets it, else software
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      global_irq_enable_reg <= 1'b0;                               // [R11]
    end else if (CE) begin
      if (take) begin
        global_irq_enable_reg <= 1'b0;                             // [R12]
      end else if (RETURN_FROM_IRQ) begin
        global_irq_enable_reg <= 1'b1;                             // [R13]
      end else if (wr_control) begin
        global_irq_enable_reg <= WDATA[`IEFC_B_GEN];
      end
    end
  end

  // plain enable bits of the control register
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      peripheral_gating_enable_reg <= 1'b0;                        // [R11]
      timer0_overflow_enable_reg   <= 1'b0;
      ext_pin_enable_reg           <= 1'b0;
      pin_change_enable_reg        <= 1'b0;
    end else if (CE && wr_control) begin
      peripheral_gating_enable_reg <= WDATA[`IEFC_B_PGEN];
      timer0_overflow_enable_reg   <= WDATA[`IEFC_B_T0IE];
      ext_pin_enable_reg           <= WDATA[`IEFC_B_EXIE];
      pin_change_enable_reg        <= WDATA[`IEFC_B_PCIE];
    end
  end

  // timer0 flag: an overflow in the clearing cycle still sets it
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      timer0_overflow_flag_reg <= 1'b0;
    end else if (CE) begin
      if (TIMER0_OVERFLOW) begin
        timer0_overflow_flag_reg <= 1'b1;                          // [R3] [R7]
      end else if (wr_control) begin
        timer0_overflow_flag_reg <= WDATA[`IEFC_B_T0IF];
      end
    end
  end

  // external pin flag: set wins over a software clear
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ext_pin_flag_reg <= 1'b0;
    end else if (CE) begin
      if (ext_edge) begin
        ext_pin_flag_reg <= 1'b1;                                  // [R4] [R7]
      end else if (wr_control) begin
        ext_pin_flag_reg <= WDATA[`IEFC_B_EXIF];
      end
    end
  end

  // summary flag is read only; it drops only once every pin flag is clear
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      pin_change_summary_flag_reg <= 1'b0;
    end else if (CE) begin
      pin_change_summary_flag_reg <= summary_now;                  // [R5] [R6] [R7]
    end
  end

  // first peripheral enable register, all bits read/write
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      peripheral_enable_one_reg <= `IEFC_RST_BYTE;                 // [R11]
    end else if (CE && wr_pe_one) begin
      peripheral_enable_one_reg <= WDATA;                          // [R9]
    end
  end

  // second peripheral enable register, all bits read/write
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      peripheral_enable_two_reg <= `IEFC_RST_BYTE;                 // [R11]
    end else if (CE && wr_pe_two) begin
      peripheral_enable_two_reg <= WDATA;                          // [R10]
    end
  end

  // sequencer next state; a new request in the isr nests if software
  // has set the global enable again
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      IEFC_IDLE: begin
        if (take) begin
          state_next = IEFC_VECTOR;
        end
      end
      IEFC_VECTOR: begin
        state_next = IEFC_IN_ISR;
      end
      IEFC_IN_ISR: begin
        if (take) begin
          state_next = IEFC_VECTOR;
        end else if (RETURN_FROM_IRQ) begin
          state_next = IEFC_IDLE;                                  // [R13]
        end
      end
      default: begin
        state_next = IEFC_IDLE;
      end
    endcase
  end

  // sequencer state register
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state_reg <= IEFC_IDLE;
    end else if (CE) begin
      state_reg <= state_next;
    end
  end

  // vector load pulse and address come from flops, one cycle after take
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      vector_load_reg <= 1'b0;
      vector_addr_reg <= `IEFC_VECTOR;
    end else if (CE) begin
      vector_load_reg <= take;                                     // [R12]
      vector_addr_reg <= `IEFC_VECTOR;                             // [R12]
    end
  end

  assign VECTOR_LOAD = vector_load_reg;
  assign VECTOR_ADDR = vector_addr_reg;

  // events worth telling software about
  always_comb begin
    ev_set                = '0;
    ev_set[`IEFC_EV_VECT] = take;
    ev_set[`IEFC_EV_RET]  = RETURN_FROM_IRQ;
    ev_set[`IEFC_EV_PCHG] = summary_now & ~pin_change_summary_flag_reg;
  end

  // sticky status, cleared by writing one; a new event beats the clear
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ev_status_reg <= `IEFC_RST_EV;
    end else if (CE) begin
      if (wr_ev_stat) begin
        ev_status_reg <= (ev_status_reg & ~WDATA[`IEFC_EV_W-1:0]) | ev_set;
      end else begin
        ev_status_reg <= ev_status_reg | ev_set;
      end
    end
  end

  // mask for the event interrupt output
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ev_mask_reg <= `IEFC_RST_EV;
    end else if (CE && wr_ev_mask) begin
      ev_mask_reg <= WDATA[`IEFC_EV_W-1:0];
    end
  end

  // event interrupt stays high while any unmasked status bit is set
  assign IRQ = |(ev_status_reg & ev_mask_reg);

  // control register as software reads it
  always_comb begin
    control_view                = `IEFC_RST_BYTE;
    control_view[`IEFC_B_GEN]   = global_irq_enable_reg;
    control_view[`IEFC_B_PGEN]  = peripheral_gating_enable_reg;
    control_view[`IEFC_B_T0IE]  = timer0_overflow_enable_reg;
    control_view[`IEFC_B_EXIE]  = ext_pin_enable_reg;
    control_view[`IEFC_B_PCIE]  = pin_change_enable_reg;
    control_view[`IEFC_B_T0IF]  = timer0_overflow_flag_reg;
    control_view[`IEFC_B_EXIF]  = ext_pin_flag_reg;
    control_view[`IEFC_B_PCIF]  = pin_change_summary_flag_reg;     // [R6]
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rdata_next = `IEFC_RST_BYTE;
    case (ADDR)
      `IEFC_OFS_CONTROL: begin
        rdata_next = control_view;
      end
      `IEFC_OFS_PE_ONE: begin
        rdata_next = peripheral_enable_one_reg;
      end
      `IEFC_OFS_PE_TWO: begin
        rdata_next = peripheral_enable_two_reg;
      end
      `IEFC_OFS_EV_STAT: begin
        rdata_next[`IEFC_EV_W-1:0] = ev_status_reg;
      end
      `IEFC_OFS_EV_MASK: begin
        rdata_next[`IEFC_EV_W-1:0] = ev_mask_reg;
      end
      default: begin
        rdata_next = `IEFC_RST_BYTE;
      end
    endcase
  end

  // read data valid only in the cycle after the strobe, zero otherwise
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      rdata_reg <= `IEFC_RST_BYTE;
    end else if (CE) begin
      rdata_reg <= RD ? rdata_next : `IEFC_RST_BYTE;
    end
  end

  assign RDATA = rdata_reg;

endmodule : iefc_top

/* File: iefc_top_asserts.sv */
/*
  Concurrent checks on the ports of the interrupt enable and flag block.
  Assumes one clock domain, synchronous active high reset, bound to iefc_top.
*/
`include "iefc_defs.svh"
`timescale 1ns/1ps
module iefc_top_chk
  import iefc_pkg::*;
(
  input wire logic                    CLOCK,                // system clock
  input wire logic                    RST,                  // synchronous reset
  input wire logic                    CE,                   // clock enable
  input wire logic [`IEFC_ADDR_W-1:0] ADDR,                 // register address
  input wire logic [`IEFC_DATA_W-1:0] WDATA,                // write data
  input wire logic                    WR,                   // write strobe
  input wire logic                    RD,                   // read strobe
  input wire logic [`IEFC_DATA_W-1:0] RDATA,                // read data
  input wire logic [7:0]              PER_PIN_CHANGE_FLAGS, // per-pin flags
  input wire logic                    RETURN_FROM_IRQ,      // core return
  input wire logic                    IRQ_REQ,              // request to core
  input wire logic                    VECTOR_LOAD,          // vector pulse
  input wire logic [`IEFC_PC_W-1:0]   VECTOR_ADDR,          // vector address
  input wire logic                    IRQ                   // event level
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  // accepted control write, qualified so reset cycles never count
  wire wr_ctl = WR && CE && !RST && (ADDR == `IEFC_OFS_CONTROL);

  AST_VEC_TAKEN: assert property (IRQ_REQ && CE |=> VECTOR_LOAD)
    else $error("request not taken on next cycle");
  AST_VEC_CAUSE: assert property (VECTOR_LOAD |-> $past(IRQ_REQ && CE))
    else $error("vector load without request");
  AST_VEC_ONCE: assert property (VECTOR_LOAD |-> !IRQ_REQ ##1 !VECTOR_LOAD)
    else $error("global enable not cleared on vector");
  AST_VEC_ADDR: assert property (VECTOR_ADDR == `IEFC_VECTOR)
    else $error("vector address wrong");
  AST_GEN_OFF: assert property ($past(wr_ctl && !WDATA[7] && !RETURN_FROM_IRQ) |-> !IRQ_REQ)
    else $error("request with global enable clear");
  AST_PGEN_OFF: assert property ($past(wr_ctl && WDATA[6:3] == 4'h0) |-> !IRQ_REQ)
    else $error("request with all gates clear");
  AST_CORE_REQ: assert property ($past(wr_ctl && !IRQ_REQ && (WDATA == 8'hA4 || WDATA == 8'h92)) |-> IRQ_REQ)
    else $error("enabled core flag gave no request");
  // summary flag seen on read is the pin-flag OR one cycle before the read
  AST_SUMMARY: assert property ($past(RD && CE && !RST && ADDR == `IEFC_OFS_CONTROL) && $past(CE, 2)
    && !$past(RST, 2) |-> RDATA[0] == (|$past(PER_PIN_CHANGE_FLAGS, 2)))
    else $error("summary flag does not follow pin flags");
  AST_RESET_QUIET: assert property ($fell(RST) |-> !IRQ_REQ && !VECTOR_LOAD && !IRQ && RDATA == 8'h00)
    else $error("outputs active after reset");
endmodule : iefc_top_chk

bind iefc_top iefc_top_chk chk (
  .CLOCK(CLOCK), .RST(RST), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .PER_PIN_CHANGE_FLAGS(PER_PIN_CHANGE_FLAGS), .RETURN_FROM_IRQ(RETURN_FROM_IRQ), .IRQ_REQ(IRQ_REQ),
  .VECTOR_LOAD(VECTOR_LOAD), .VECTOR_ADDR(VECTOR_ADDR), .IRQ(IRQ)
);

/* File: iefc_core_model.sv */
/*
  Behavioural core: counts vectors and returns after a set service time.
  Assumes vector_load is a one-cycle pulse on the shared clock.
*/
`timescale 1ns/1ps
module iefc_core_model
  import iefc_pkg::*;
(
  input  wire logic       clk,          // system clock
  input  wire logic       rst,          // synchronous reset
  input  wire logic       auto_ret,     // return when service time ends
  input  wire logic [7:0] isr_len,      // service time in cycles
  input  wire logic       vector_load,  // vector pulse from block
  output logic            return_pulse, // one-cycle return
  output int              vec_count     // vectors seen
);
  logic       busy_reg;
  logic [7:0] cnt_reg;

  // service routine timer; without auto_ret the core stays in service
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_reg     <= 1'b0;
      cnt_reg      <= 8'h00;
      return_pulse <= 1'b0;
      vec_count    <= 0;
    end else begin
      return_pulse <= 1'b0;
      if (vector_load) begin
        busy_reg  <= 1'b1;
        cnt_reg   <= 8'h00;
        vec_count <= vec_count + 1;
      end else if (busy_reg) begin
        cnt_reg <= cnt_reg + 8'h01;
        if (auto_ret && cnt_reg == isr_len) begin
          return_pulse <= 1'b1;
          busy_reg     <= 1'b0;
        end
      end
    end
  end
endmodule : iefc_core_model

/* File: iefc_top_test.sv */
/*
  Self-checking bench for iefc_top with a behavioural core beside it.
  Assumes the checker is bound to the top module from its own file.
*/
`include "iefc_defs.svh"
`timescale 1ns/1ps
module iefc_top_test
  import iefc_pkg::*;
;
  logic CLOCK, RST, CE, WR, RD, TIMER0_OVERFLOW, EXT_PIN, EXT_EDGE_SELECT, RETURN_FROM_IRQ;
  logic IRQ_REQ, VECTOR_LOAD, IRQ, auto_ret, rd_seen;
  logic [2:0]  ADDR;
  logic [7:0]  WDATA, RDATA, PER_PIN_CHANGE_FLAGS, PERIPH_FLAGS_ONE, PERIPH_FLAGS_TWO;
  logic [13:0] VECTOR_ADDR;
  logic [7:0]  exp_q[$];
  int          n_fail, n_tests, vec_count;

  iefc_top dut (.CLOCK(CLOCK), .RST(RST), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .TIMER0_OVERFLOW(TIMER0_OVERFLOW), .EXT_PIN(EXT_PIN), .EXT_EDGE_SELECT(EXT_EDGE_SELECT),
    .PER_PIN_CHANGE_FLAGS(PER_PIN_CHANGE_FLAGS), .PERIPH_FLAGS_ONE(PERIPH_FLAGS_ONE),
    .PERIPH_FLAGS_TWO(PERIPH_FLAGS_TWO), .RETURN_FROM_IRQ(RETURN_FROM_IRQ), .IRQ_REQ(IRQ_REQ),
    .VECTOR_LOAD(VECTOR_LOAD), .VECTOR_ADDR(VECTOR_ADDR), .IRQ(IRQ));
  iefc_core_model core (.clk(CLOCK), .rst(RST), .auto_ret(auto_ret), .isr_len(8'h06),
    .vector_load(VECTOR_LOAD), .return_pulse(RETURN_FROM_IRQ), .vec_count(vec_count));

  // 25 ns clock
  initial begin
    CLOCK = 1'b0;
    forever #12.5 CLOCK = ~CLOCK;
  end

  task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  task automatic wr(logic [2:0] a, logic [7:0] d);
    @(posedge CLOCK);
    WR <= 1'b1; ADDR <= a; WDATA <= d;
    @(posedge CLOCK);
    WR <= 1'b0;
  endtask : wr

  // read note goes on the queue; the monitor compares it a cycle later
  task automatic rd(logic [2:0] a, logic [7:0] e);
    @(posedge CLOCK);
    RD <= 1'b1; ADDR <= a; exp_q.push_back(e);
    @(posedge CLOCK);
    RD <= 1'b0;
  endtask : rd

  task automatic cyc(int n);
    repeat (n) @(posedge CLOCK);
  endtask : cyc

  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13; s ^= s >> 17; s ^= s << 5;
    return s;
  endfunction : xs

  // read data stands only in the cycle after the strobe
  always @(posedge CLOCK) begin
    rd_seen <= RD && CE;
    if (rd_seen) check("rdata", RDATA, exp_q.pop_front());
  end

  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    cyc(5000);
    n_fail++;
    wrap_up();
  end

  initial begin
    logic [31:0] seed;
    logic [7:0]  e1, e2;
    {RST, CE, WR, RD, TIMER0_OVERFLOW, EXT_PIN, EXT_EDGE_SELECT, auto_ret, rd_seen} = 9'b110000100;
    {ADDR, WDATA, PER_PIN_CHANGE_FLAGS, PERIPH_FLAGS_ONE, PERIPH_FLAGS_TWO} = 35'h0;
    n_fail = 0; n_tests = 0; seed = 32'hf606;
    cyc(20);
    RST <= 1'b0;
    for (int a = 0; a < 8; a++) rd(a[2:0], 8'h00);
    $display("test reset values finished");
    wr(1, 8'hA5); wr(2, 8'h5A); wr(7, 8'hFF);
    rd(1, 8'hA5); rd(2, 8'h5A); rd(7, 8'h00);
    @(posedge CLOCK) CE <= 1'b0;
    wr(1, 8'hFF); CE <= 1'b1;
    rd(1, 8'hA5);
    $display("test enable registers finished");
    wr(1, 8'h00); wr(2, 8'h00);
    @(posedge CLOCK) TIMER0_OVERFLOW <= 1'b1;
    @(posedge CLOCK) TIMER0_OVERFLOW <= 1'b0;
    rd(0, 8'h04);
    check("req gated", IRQ_REQ, 1'b0);
    auto_ret <= 1'b1;
    wr(0, 8'hA4); #1;
    check("req timer", IRQ_REQ, 1'b1);
    @(posedge CLOCK) #1;
    check("vector", VECTOR_LOAD, 1'b1);
    check("req after take", IRQ_REQ, 1'b0);
    wr(0, 8'h20); cyc(10);
    rd(0, 8'hA0);
    check("vectors", vec_count[7:0], 8'h01);
    rd(3, 8'h03);
    auto_ret <= 1'b0;
    wr(0, 8'h00);
    $display("test timer path finished");
    EXT_PIN <= 1'b1; cyc(6);
    rd(0, 8'h02);
    // the falling edge back to low sets the flag again, so clear it only afterwards
    EXT_EDGE_SELECT <= 1'b0; EXT_PIN <= 1'b0; cyc(6);
    wr(0, 8'h00); EXT_PIN <= 1'b1; cyc(6);
    rd(0, 8'h00);
    EXT_PIN <= 1'b0; cyc(6);
    rd(0, 8'h02);
    wr(0, 8'h92); #1;
    check("req ext", IRQ_REQ, 1'b1);
    wr(0, 8'h00);
    $display("test external pin finished");
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      PERIPH_FLAGS_ONE <= seed[7:0]; PERIPH_FLAGS_TWO <= seed[15:8];
      e1 = seed[23:16]; e2 = seed[31:24];
      wr(1, e1); wr(2, e2);
      wr(0, {1'b1, seed[3], 6'h00}); #1;
      check("req periph", IRQ_REQ, seed[3] & |((seed[7:0] & e1) | (seed[15:8] & e2)));
      wr(0, 8'h00);
    end
    $display("test peripheral gating finished");
    wr(3, 8'h07); wr(4, 8'h04);
    PER_PIN_CHANGE_FLAGS <= 8'h10; cyc(3);
    rd(0, 8'h01);
    wr(0, 8'h00);
    rd(0, 8'h01);
    rd(3, 8'h04); #1;
    check("irq raised", IRQ, 1'b1);
    wr(4, 8'h00); #1;
    check("irq masked", IRQ, 1'b0);
    wr(4, 8'h04); wr(3, 8'h04); #1;
    check("irq cleared", IRQ, 1'b0);
    @(posedge CLOCK) PER_PIN_CHANGE_FLAGS <= 8'h00;
    cyc(3);
    rd(0, 8'h00); rd(3, 8'h00);
    $display("test change flag and events finished");
    wr(1, 8'h3C); wr(0, 8'hF8);
    @(posedge CLOCK) RST <= 1'b1;
    cyc(2); RST <= 1'b0;
    for (int a = 0; a < 5; a++) rd(a[2:0], 8'h00);
    $display("test second reset finished");
    cyc(2);
    wrap_up();
  end
endmodule : iefc_top_test
